// ### hdl/nvsc_host.sv
// host controller driving an nv sram over its select/strobe/store/recall pins
// Behaviour
// [RL1] select is driven low for every read and write; released high otherwise
// [RL2] write strobe high reads, low writes the data pins
// [RL3] eight address lines pick one of 256 four-bit locations
// [RL4] device floats data during store and recall; host never drives then
// [RL5] store low copies ram to shadow array; finishes within 10 ms
// [RL6] during store, device ignores write strobe and recall
// [RL7] store beats ram access; a read in progress is abandoned
// [RL8] store during write aborts it; that location becomes undefined
// [RL9] store pulse needs only 100 ns minimum; device finishes alone
// [RL10] deselecting does not abort a running store
// [RL11] store pulses under 20 ns are filtered and start nothing
// [RL12] recall low copies shadow to ram; pulse 450 ns, cycle 1200 ns
// [RL13] recall beats ram access; ongoing read or write terminated
// [RL14] store is ignored while recall is held low
// [RL15] recalled data readable 750 ns after recall release
// [RL16] store held high through reset and power transitions
// [RL17] store reprograms only differing shadow bits
// [RL18] store leaves ram contents unchanged
`timescale 1ns/1ns
`default_nettype none

module nvsc_host (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire nvsc_pkg::nvsc_req_s req_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  output logic [nvsc_pkg::DATA_W-1:0] rdata_o,
  output logic rdata_valid_o,
  output logic busy_o,
  output logic [nvsc_pkg::ADDR_W-1:0] addr_lines_o,
  output logic sel_n_o,
  output logic wr_n_o,
  output logic store_n_o,
  output logic recall_n_o,
  input wire logic [nvsc_pkg::DATA_W-1:0] data_pins_i,
  output logic [nvsc_pkg::DATA_W-1:0] data_pins_o,
  output logic data_pins_oe_o
);

  // ---------------------------------------------------------------
  // state and registers
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    NVSC_ST_IDLE = 3'b000,
    NVSC_ST_READ = 3'b001,
    NVSC_ST_WSETUP = 3'b010,
    NVSC_ST_WPULSE = 3'b011,
    NVSC_ST_WRECOV = 3'b100,
    NVSC_ST_STPULSE = 3'b101,
    NVSC_ST_STWAIT = 3'b110,
    NVSC_ST_RECALL = 3'b111
  } nvsc_state_e;

  nvsc_state_e state_q, state_d;
  logic [nvsc_pkg::CNT_W-1:0] cnt_q, cnt_d;
  nvsc_pkg::nvsc_req_s req_q;
  nvsc_pkg::nvsc_ctl_s ctl_q, ctl_d;
  logic oe_q, oe_d;
  logic [nvsc_pkg::DATA_W-1:0] rdata_q;
  logic rvalid_q;
  logic [nvsc_pkg::DATA_W-1:0] din_m_q, din_s_q;
  logic cnt_done;
  logic take;

  assign cnt_done = (cnt_q == nvsc_pkg::CNT_ZERO);
  assign take = req_valid_i && (state_q == NVSC_ST_IDLE);

  // ---------------------------------------------------------------
  // data pin synchroniser
  // ---------------------------------------------------------------
  // two-flop capture of the asynchronous data pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      din_m_q <= 4'h0;
      din_s_q <= 4'h0;
    end else begin
      din_m_q <= data_pins_i;
      din_s_q <= din_m_q;
    end
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  // next state, counter and pin levels
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_done ? cnt_q : cnt_q - 24'h00_0001;
    ctl_d = ctl_q;
    oe_d = oe_q;
    case (state_q)
      NVSC_ST_IDLE: begin
        ctl_d = nvsc_pkg::CTL_IDLE; // RL16
        oe_d = 1'b0;
        if (req_valid_i) begin
          case (req_i.cmd)
            nvsc_pkg::NVSC_CMD_READ: begin
              state_d = NVSC_ST_READ;
              ctl_d.sel_n = 1'b0; // RL1
              ctl_d.wr_n = 1'b1; // RL2
              cnt_d = nvsc_pkg::CNT_W'(nvsc_pkg::RD_CYC + 2);
            end
            nvsc_pkg::NVSC_CMD_WRITE: begin
              state_d = NVSC_ST_WSETUP;
              ctl_d.sel_n = 1'b0; // RL1
              oe_d = 1'b1;
              cnt_d = nvsc_pkg::CNT_W'(nvsc_pkg::AS_CYC);
            end
            nvsc_pkg::NVSC_CMD_STORE: begin
              state_d = NVSC_ST_STPULSE;
              ctl_d.store_n = 1'b0; // RL5
              cnt_d = nvsc_pkg::CNT_W'(nvsc_pkg::STP_CYC); // RL9 RL11
            end
            nvsc_pkg::NVSC_CMD_RECALL: begin
              state_d = NVSC_ST_RECALL;
              ctl_d.recall_n = 1'b0; // RL12
              cnt_d = nvsc_pkg::CNT_W'(nvsc_pkg::RCP_CYC);
            end
            default: state_d = NVSC_ST_IDLE;
          endcase
        end
      end
      NVSC_ST_READ: begin
        if (cnt_done) begin
          state_d = NVSC_ST_IDLE;
          ctl_d.sel_n = 1'b1;
        end
      end
      NVSC_ST_WSETUP: begin
        if (cnt_done) begin
          state_d = NVSC_ST_WPULSE;
          ctl_d.wr_n = 1'b0; // RL2
          cnt_d = nvsc_pkg::CNT_W'(nvsc_pkg::WP_CYC);
        end
      end
      NVSC_ST_WPULSE: begin
        if (cnt_done) begin
          state_d = NVSC_ST_WRECOV;
          ctl_d.wr_n = 1'b1;
          cnt_d = nvsc_pkg::CNT_W'(nvsc_pkg::WR_CYC);
        end
      end
      NVSC_ST_WRECOV: begin
        if (cnt_done) begin
          state_d = NVSC_ST_IDLE;
          ctl_d.sel_n = 1'b1;
          oe_d = 1'b0;
        end
      end
      NVSC_ST_STPULSE: begin
        // deselected and quiet while the device stores on its own
        if (cnt_done) begin
          state_d = NVSC_ST_STWAIT;
          ctl_d.store_n = 1'b1; // RL9
          cnt_d = nvsc_pkg::CNT_W'(nvsc_pkg::STC_CYC); // RL5 RL10
        end
      end
      NVSC_ST_STWAIT: begin
        if (cnt_done) begin
          state_d = NVSC_ST_IDLE; // RL6
        end
      end
      NVSC_ST_RECALL: begin
        // hold recall for the pulse, then wait out cycle and access time
        if (cnt_done && !ctl_q.recall_n) begin
          ctl_d.recall_n = 1'b1;
          cnt_d = nvsc_pkg::CNT_W'(nvsc_pkg::ARC_CYC + nvsc_pkg::RCC_CYC
                                   - nvsc_pkg::RCP_CYC); // RL12 RL15
        end else if (cnt_done) begin
          state_d = NVSC_ST_IDLE;
        end
      end
      default: begin
        state_d = NVSC_ST_IDLE;
        ctl_d = nvsc_pkg::CTL_IDLE;
        oe_d = 1'b0;
      end
    endcase
  end

  // state registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= NVSC_ST_IDLE;
      cnt_q <= nvsc_pkg::CNT_ZERO;
      ctl_q <= nvsc_pkg::CTL_IDLE; // RL16
      oe_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      ctl_q <= ctl_d;
      oe_q <= oe_d; // RL4
    end
  end

  // request capture
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_q <= '0;
    end else if (take) begin
      req_q <= req_i; // RL3
    end
  end

  // read data capture at end of read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= 4'h0;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= (state_q == NVSC_ST_READ) && cnt_done;
      if ((state_q == NVSC_ST_READ) && cnt_done) begin
        rdata_q <= din_s_q;
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign req_ready_o = (state_q == NVSC_ST_IDLE);
  assign busy_o = (state_q != NVSC_ST_IDLE);
  assign rdata_o = rdata_q;
  assign rdata_valid_o = rvalid_q;
  assign addr_lines_o = req_q.addr; // RL3
  assign sel_n_o = ctl_q.sel_n;
  assign wr_n_o = ctl_q.wr_n;
  assign store_n_o = ctl_q.store_n;
  assign recall_n_o = ctl_q.recall_n;
  assign data_pins_o = req_q.wdata;
  assign data_pins_oe_o = oe_q;

endmodule // nvsc_host

`default_nettype wire

// ### hdl/nvsc_pkg.sv
// package: timing constants and command carriers for the nv sram host controller
package nvsc_pkg;

  // ---------------------------------------------------------------
  // clock
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 8;

  // ---------------------------------------------------------------
  // device timing figures in their own units
  // ---------------------------------------------------------------
  localparam int unsigned T_RC_NS = 250;      // read cycle
  localparam int unsigned T_ACC_NS = 250;     // access time
  localparam int unsigned T_AS_NS = 50;       // address setup
  localparam int unsigned T_WP_NS = 150;      // write pulse
  localparam int unsigned T_WR_NS = 25;       // write recovery
  localparam int unsigned T_STP_NS = 100;     // store pulse
  localparam int unsigned T_STC_MS = 10;      // store cycle
  localparam int unsigned T_RCP_NS = 450;     // recall pulse
  localparam int unsigned T_RCC_NS = 1200;    // recall cycle
  localparam int unsigned T_ARC_NS = 750;     // recalled data access

  // ---------------------------------------------------------------
  // cycle counts, least times rounded up
  // ---------------------------------------------------------------
  localparam int unsigned RD_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned AS_CYC = (T_AS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WR_CYC = (T_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STP_CYC = (T_STP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STC_CYC = (T_STC_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RCP_CYC = (T_RCP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RCC_CYC = (T_RCC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ARC_CYC = (T_ARC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned CNT_W = 24;
  localparam logic [CNT_W-1:0] CNT_ZERO = 24'h00_0000;

  // ---------------------------------------------------------------
  // widths and command codes
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 4;

  typedef enum logic [1:0] {
    NVSC_CMD_READ = 2'b00,
    NVSC_CMD_WRITE = 2'b01,
    NVSC_CMD_STORE = 2'b10,
    NVSC_CMD_RECALL = 2'b11
  } nvsc_cmd_e;

  typedef struct packed {
    nvsc_cmd_e cmd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } nvsc_req_s;

  typedef struct packed {
    logic sel_n;
    logic wr_n;
    logic store_n;
    logic recall_n;
  } nvsc_ctl_s;

  localparam nvsc_ctl_s CTL_IDLE = 4'b1111;

endpackage : nvsc_pkg

// ### verif/nvsc_dev.sv
// partner: behavioural nv sram with a shadow array
`timescale 1ns/1ns
`default_nettype none
module nvsc_dev #(
  parameter int ACC_NS = 250,
  parameter int STC_NS = 100
) (
  input wire logic [7:0] addr_i,
  input wire logic sel_n_i,
  input wire logic wr_n_i,
  input wire logic store_n_i,
  input wire logic recall_n_i,
  input wire logic [3:0] din_i,
  output logic [3:0] dq_o
);
  logic [3:0] ram [256];
  logic [3:0] shadow [256];
  logic st_busy = 1'b0;
  time t0 = 64'h0fff_ffff;
  initial foreach (shadow[i]) shadow[i] = i[3:0] ^ 4'h5;
  initial foreach (ram[i]) ram[i] = 4'h0;
  // store or recall low abandons any read in progress
  wire logic rd_en = !sel_n_i && wr_n_i && store_n_i && recall_n_i && !st_busy;
  assign #ACC_NS dq_o = rd_en ? ram[addr_i] : ~ram[addr_i];
  always @(posedge wr_n_i) if (!sel_n_i && !st_busy && store_n_i && recall_n_i) ram[addr_i] = din_i;
  // store cutting into a write leaves that location unknown
  always @(negedge store_n_i) begin
    t0 = $time;
    if (!sel_n_i && !wr_n_i && !st_busy && recall_n_i) ram[addr_i] = 4'hx;
  end
  always @(posedge store_n_i) if ($time >= t0 + 20 && recall_n_i && !st_busy) begin
    foreach (ram[i]) if (shadow[i] !== ram[i]) shadow[i] = ram[i];
    st_busy = 1'b1;
    #STC_NS st_busy = 1'b0;
  end
  always @(negedge recall_n_i) if (!st_busy) foreach (ram[i]) ram[i] = shadow[i];
endmodule // nvsc_dev
`default_nettype wire

// ### verif/nvsc_host_tb.sv
// testbench: host controller against the behavioural nv sram
`timescale 1ns/1ns
`default_nettype none
module nvsc_host_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  nvsc_pkg::nvsc_req_s req_i = '0;
  logic req_valid_i = 1'b0;
  logic rdy, rvld, busy, sel_n, wr_n, st_n, rc_n, oe;
  logic [3:0] rdata, dq, dout;
  logic [7:0] addr;
  int errors = 0;
  int checks = 0;
  always #4 clk_i = ~clk_i;
  nvsc_host nvsc_host_i (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .req_valid_i(req_valid_i),
    .req_ready_o(rdy), .rdata_o(rdata), .rdata_valid_o(rvld), .busy_o(busy),
    .addr_lines_o(addr), .sel_n_o(sel_n), .wr_n_o(wr_n), .store_n_o(st_n), .recall_n_o(rc_n),
    .data_pins_i(dq), .data_pins_o(dout), .data_pins_oe_o(oe));
  nvsc_dev nvsc_dev_i (.addr_i(addr), .sel_n_i(sel_n), .wr_n_i(wr_n), .store_n_i(st_n),
    .recall_n_i(rc_n), .din_i(dout), .dq_o(dq));
  task automatic results();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic step(inout int n, input int lim);
    @(negedge clk_i);
    n++;
    if (n > lim) begin
      errors++;
      $display("CHECK FAILED %0t wait ran out", $time);
      results();
    end
  endtask
  task automatic req(input nvsc_pkg::nvsc_cmd_e c, input logic [7:0] a, input logic [3:0] d);
    int n;
    n = 0;
    while (rdy !== 1'b1) step(n, 400);
    req_i = '{c, a, d};
    req_valid_i = 1'b1;
    @(negedge clk_i);
    req_valid_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [3:0] e);
    int n;
    n = 0;
    req(nvsc_pkg::NVSC_CMD_READ, a, 4'h0);
    while (rvld !== 1'b1) step(n, 60);
    chk(rdata, e);
  endtask
  task automatic t_rw();
    logic [7:0] a [4] = '{8'h00, 8'hff, 8'h5a, 8'ha5};
    foreach (a[i]) req(nvsc_pkg::NVSC_CMD_WRITE, a[i], ~a[i][7:4]);
    foreach (a[i]) rd(a[i], ~a[i][7:4]);
    $display("t_rw done");
  endtask
  task automatic t_recall();
    int n;
    n = 0;
    req(nvsc_pkg::NVSC_CMD_WRITE, 8'h10, 4'h3);
    req(nvsc_pkg::NVSC_CMD_RECALL, 8'h00, 4'h0);
    while (rc_n !== 1'b0) step(n, 10);
    n = 0;
    while (rc_n === 1'b0) step(n, 100);
    chk(n >= 57 ? 4'h1 : 4'h0, 4'h1);
    rd(8'h10, 4'h5);
    $display("t_recall done");
  endtask
  task automatic t_store();
    int n;
    n = 0;
    req(nvsc_pkg::NVSC_CMD_WRITE, 8'h20, 4'hc);
    req(nvsc_pkg::NVSC_CMD_STORE, 8'h00, 4'h0);
    while (st_n !== 1'b0) step(n, 10);
    n = 0;
    while (st_n === 1'b0) step(n, 100);
    chk(n >= 13 ? 4'h1 : 4'h0, 4'h1);
    chk(nvsc_dev_i.shadow[8'h20], 4'hc);
    repeat (10) @(negedge clk_i);
    chk({3'h0, busy}, 4'h1);
    rst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    rd(8'h20, 4'hc);
    $display("t_store done");
  endtask
  initial begin
    repeat (6) @(negedge clk_i);
    rst_i = 1'b0;
    t_rw();
    t_recall();
    t_store();
    results();
  end
endmodule // nvsc_host_tb
`default_nettype wire

// ### verif/nvsc_props.sv
// checker: port-level properties of the nv sram host controller
`timescale 1ns/1ns
`default_nettype none
module nvsc_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire nvsc_pkg::nvsc_req_s req_i,
  input wire logic req_valid_i,
  input wire logic req_ready_o,
  input wire logic rdata_valid_o,
  input wire logic busy_o,
  input wire logic [nvsc_pkg::ADDR_W-1:0] addr_lines_o,
  input wire logic sel_n_o,
  input wire logic wr_n_o,
  input wire logic store_n_o,
  input wire logic recall_n_o,
  input wire logic data_pins_oe_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_oe_needs_sel: assert property (data_pins_oe_o |-> !sel_n_o && store_n_o && recall_n_o)
    else $error("data driven outside a select");
  a_read_answer: assert property (req_valid_i && req_ready_o && req_i.cmd ==
    nvsc_pkg::NVSC_CMD_READ |-> ##36 rdata_valid_o)
    else $error("read data not returned on time");
  a_write_pulse: assert property ($fell(wr_n_o) |-> !sel_n_o ##19 !wr_n_o ##1 wr_n_o)
    else $error("write strobe width wrong");
  a_store_pulse: assert property ($fell(store_n_o) |-> ##13 !store_n_o ##1 store_n_o)
    else $error("store pulse width wrong");
  a_recall_pulse: assert property ($fell(recall_n_o) |-> ##57 !recall_n_o ##1 recall_n_o)
    else $error("recall pulse width wrong");
  a_store_no_sel: assert property (!store_n_o |-> sel_n_o && !data_pins_oe_o)
    else $error("ram access during store");
  a_recall_alone: assert property (!recall_n_o |-> sel_n_o && store_n_o)
    else $error("access or store during recall");
  a_addr_hold: assert property (!sel_n_o && $past(!sel_n_o) |-> $stable(addr_lines_o))
    else $error("address moved while selected");
  a_reset_idle: assert property ($past(rst_i) |-> store_n_o && recall_n_o && sel_n_o)
    else $error("pins not idle after reset");
  a_recall_wait: assert property ($rose(recall_n_o) |-> ##150 busy_o)
    else $error("recalled data used too early");
  a_store_busy: assert property ($rose(store_n_o) |-> busy_o[*8])
    else $error("store wait cut short");
endmodule // nvsc_props
bind nvsc_host nvsc_props nvsc_props_i (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i),
  .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .rdata_valid_o(rdata_valid_o),
  .busy_o(busy_o), .addr_lines_o(addr_lines_o), .sel_n_o(sel_n_o), .wr_n_o(wr_n_o),
  .store_n_o(store_n_o), .recall_n_o(recall_n_o), .data_pins_oe_o(data_pins_oe_o));
`default_nettype wire
